// ==== chc_pkg.sv ====
// Package: shared constants, types and helpers for the channel hop control block
package chc_pkg;
	// ==================================================
	// Register offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_INTE = 12'h004;
	localparam logic [11:0] A_FRAC = 12'h008;
	localparam logic [11:0] A_STEP = 12'h00C;
	localparam logic [11:0] A_THR  = 12'h010;
	localparam logic [11:0] A_SIZE = 12'h014;
	localparam logic [11:0] A_BAND = 12'h018;
	localparam logic [11:0] A_CMD  = 12'h01C;
	localparam logic [11:0] A_AMP  = 12'h020;
	localparam logic [11:0] A_RAMP = 12'h024;
	localparam logic [11:0] A_STAT = 12'h028;
	localparam logic [11:0] A_SYN  = 12'h02C;
	localparam logic [3:0]  A_TAB_PAGE = 4'h1;
	// ==================================================
	// Field positions
	localparam int B_HOP = 0;
	localparam int B_RSSI = 1;
	localparam int B_PRE = 2;
	localparam int B_SYNC = 3;
	localparam int B_PKT = 4;
	localparam int CMD_CHV = 8;
	localparam int CMD_OP_LSB = 9;
	localparam int CMD_VCO_LSB = 16;
	localparam int AMP_EXT_BIT = 7;
	localparam int STAT_CH_LSB = 2;
	localparam int STAT_IDX_LSB = 10;
	localparam int FRAC_BITS = 19;
	// ==================================================
	// Reset values and codes
	localparam logic [4:0]  RST_CTRL = 5'h00;
	localparam logic [7:0]  RST_INTE = 8'h00;
	localparam logic [23:0] RST_FRAC = 24'h080000;
	localparam logic [15:0] RST_STEP = 16'h0000;
	localparam logic [7:0]  RST_THR  = 8'hFF;
	localparam logic [6:0]  RST_SIZE = 7'h40;
	localparam logic [2:0]  RST_BAND = 3'h4;
	localparam logic [7:0]  RST_CHAN = 8'h00;
	localparam logic [7:0]  RST_AMP  = 8'h00;
	localparam logic [3:0]  RST_TC   = 4'h0;
	localparam logic [7:0]  SKIP = 8'hFF;
	localparam int TAB_DEPTH = 64;
	localparam logic [1:0] OP_STOP = 2'h0;
	localparam logic [1:0] OP_RX = 2'h1;
	localparam logic [1:0] OP_TX = 2'h2;
	localparam logic [1:0] OP_HOP = 2'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_DWELL, ST_STAY, ST_TX} chc_state_t;
	// ==================================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int RAMP_STEPS = 255;
	localparam int RAMP_NS [16] = '{1250, 1330, 1430, 1540, 1670, 1820, 2000, 2220,
		2500, 2860, 3330, 4000, 5000, 6670, 10000, 20000};
	// Cycles per level step from the ramp time, rounds down, never below one cycle
	function automatic logic [15:0] ramp_div(input logic [3:0] tc);
		int c;
		c = RAMP_NS[tc] * CLK_MHZ / 1000 / RAMP_STEPS;
		ramp_div = (c < 1) ? 16'h0001 : c[15:0];
	endfunction : ramp_div
	// Band code to output divide ratio
	function automatic logic [4:0] outdiv_of(input logic [2:0] band);
		case (band)
			3'h0: outdiv_of = 5'h18;
			3'h1: outdiv_of = 5'h0C;
			3'h2: outdiv_of = 5'h0A;
			3'h3: outdiv_of = 5'h08;
			default: outdiv_of = 5'h04;
		endcase
	endfunction : outdiv_of
endpackage : chc_pkg

// ==== chc_ramp.sv ====
// External amplifier ramp generator
`timescale 1ns/10ps
`default_nettype none
module chc_ramp (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       en,
	input  wire logic       up,
	input  wire logic [3:0] tc,
	output logic      [7:0] level_r
);
	logic [15:0] div_r;

	// ==================================================
	// Step pacing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 16'h0000;
		end else if (div_r + 16'h0001 >= chc_pkg::ramp_div(tc)) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// ==================================================
	// Level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 8'h00;
		end else if (!en) begin
			level_r <= 8'h00;
		end else if (div_r == 16'h0000) begin
			if (up && level_r != 8'hFF) begin
				level_r <= level_r + 8'h01;
			end else if (!up && level_r != 8'h00) begin
				level_r <= level_r - 8'h01;
			end
		end
	end

	// ==================================================
	// Checks
	property p_ext_off;
		@(posedge pclk) disable iff (!presetn) !en |=> level_r == 8'h00;
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("ramp active while disabled");
	property p_ramp_dir;
		@(posedge pclk) disable iff (!presetn) en && up && $past(en) && $past(up)
			|-> level_r >= $past(level_r);
	endproperty
	a_ramp_dir: assert property (p_ramp_dir) else $error("ramp fell while up");
endmodule : chc_ramp
`default_nettype wire

// ==== chc_top.sv ====
// Channel hop control: APB registers, channel tuning, hop sequencer, amp ramp
`timescale 1ns/10ps
`default_nettype none
module chc_top #(
	parameter int DWELL_CYC = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  rssi_now,
	input  wire logic        preamble_timeout,
	input  wire logic        sync_timeout,
	input  wire logic        sync_found,
	input  wire logic        tx_done,
	output logic      [27:0] synth_word,
	output logic      [4:0]  out_div,
	output logic             synth_load,
	output logic      [15:0] oscillator_count_value,
	output logic             osc_count_ext,
	output logic             hop_pin,
	output logic             wrap_pin,
	output logic             pa_ramp_on,
	output logic      [7:0]  external_amp_ramp_out
);
	generate
		if (DWELL_CYC < 1 || DWELL_CYC > 65535) begin : g_bad
			$error("DWELL_CYC out of range");
		end
	endgenerate

	// ==================================================
	// Registers and state
	logic [4:0]  ctrl_r;
	logic [7:0]  inte_r;
	logic [23:0] frac_r;
	logic [15:0] step_r;
	logic [7:0]  signal_level_threshold;
	logic [6:0]  size_r;
	logic [2:0]  band_r;
	logic [7:0]  amplifier_mode_setting;
	localparam int TABLE_N = chc_pkg::TAB_DEPTH;
	logic [3:0]  ramp_time_code;
	logic [7:0]  hop_tab [TABLE_N];
	logic [7:0]  chan_r;
	logic [5:0]  idx_r;
	logic [15:0] dwell_r;
	chc_pkg::chc_state_t st_r;

	logic        acc_en, wr_en, cmd_wr, tab_hit;
	logic [1:0]  cmd_op;
	logic [7:0]  cmd_ch;
	logic        dwell_done, stay_ev, hop_ev, hop_go, tune_go;
	logic [7:0]  tune_ch;
	logic [5:0]  nxt_i, first_i;
	logic [31:0] rd_nxt;
	logic        err_nxt;

	assign acc_en = psel & penable & pready;
	assign wr_en  = acc_en & pwrite;
	assign tab_hit = paddr[11:8] == chc_pkg::A_TAB_PAGE;
	assign cmd_wr = wr_en && paddr == chc_pkg::A_CMD;
	assign cmd_op = pwdata[chc_pkg::CMD_OP_LSB +: 2];
	assign cmd_ch = pwdata[chc_pkg::CMD_CHV] ? pwdata[7:0] : chan_r;

	// Next entry in table order, wrapping at size
	function automatic logic [5:0] nxt_idx(input logic [5:0] from);
		logic [5:0] k;
		logic       fnd;
		nxt_idx = from;
		fnd = 1'b0;
		k = from;
		for (int i = 0; i < TABLE_N; i++) begin
			k = ({1'b0, k} + 7'h01 >= size_r) ? 6'h00 : k + 6'h01;
			if (!fnd && hop_tab[k] != chc_pkg::SKIP) begin
				nxt_idx = k;
				fnd = 1'b1;
			end
		end
	endfunction : nxt_idx

	function automatic logic [27:0] synth_calc(input logic [7:0] ch);
		synth_calc = {1'b0, inte_r, 19'h00000} + {4'h0, frac_r}
			+ {4'h0, 24'(ch) * 24'(step_r)};
	endfunction : synth_calc

	// ==================================================
	// APB slave
	always_comb begin
		rd_nxt = 32'h00000000;
		err_nxt = 1'b0;
		if (tab_hit) begin
			rd_nxt = {24'h000000, hop_tab[paddr[7:2]]};
		end else begin
			case (paddr)
				chc_pkg::A_CTRL: rd_nxt = {27'h0000000, ctrl_r};
				chc_pkg::A_INTE: rd_nxt = {24'h000000, inte_r};
				chc_pkg::A_FRAC: rd_nxt = {8'h00, frac_r};
				chc_pkg::A_STEP: rd_nxt = {16'h0000, step_r};
				chc_pkg::A_THR:  rd_nxt = {24'h000000, signal_level_threshold};
				chc_pkg::A_SIZE: rd_nxt = {25'h0000000, size_r};
				chc_pkg::A_BAND: rd_nxt = {29'h00000000, band_r};
				chc_pkg::A_CMD:  rd_nxt = 32'h00000000;
				chc_pkg::A_AMP:  rd_nxt = {24'h000000, amplifier_mode_setting};
				chc_pkg::A_RAMP: rd_nxt = {28'h0000000, ramp_time_code};
				chc_pkg::A_STAT: rd_nxt = {16'h0000, idx_r, chan_r, st_r};
				chc_pkg::A_SYN:  rd_nxt = {4'h0, synth_word};
				default: err_nxt = 1'b1;
			endcase
		end
	end

	// Answer one cycle after setup; data held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata <= pwrite ? 32'h00000000 : rd_nxt;
				pslverr <= err_nxt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= chc_pkg::RST_CTRL;
			inte_r <= chc_pkg::RST_INTE;
			frac_r <= chc_pkg::RST_FRAC;
			step_r <= chc_pkg::RST_STEP;
			signal_level_threshold <= chc_pkg::RST_THR;
			size_r <= chc_pkg::RST_SIZE;
			band_r <= chc_pkg::RST_BAND;
			amplifier_mode_setting <= chc_pkg::RST_AMP;
			ramp_time_code <= chc_pkg::RST_TC;
		end else if (wr_en) begin
			case (paddr)
				chc_pkg::A_CTRL: ctrl_r <= pwdata[4:0];
				chc_pkg::A_INTE: inte_r <= pwdata[7:0];
				chc_pkg::A_FRAC: frac_r <= pwdata[23:0];
				chc_pkg::A_STEP: step_r <= pwdata[15:0];
				chc_pkg::A_THR:  signal_level_threshold <= pwdata[7:0];
				// Size above the table depth would index past it
				chc_pkg::A_SIZE: size_r <= (pwdata[6:0] > 7'h40) ? 7'h40 : pwdata[6:0];
				chc_pkg::A_BAND: band_r <= pwdata[2:0];
				chc_pkg::A_AMP:  amplifier_mode_setting <= pwdata[7:0];
				chc_pkg::A_RAMP: ramp_time_code <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < TABLE_N; i++) begin
				hop_tab[i] <= chc_pkg::SKIP;
			end
		end else if (wr_en && tab_hit) begin
			hop_tab[paddr[7:2]] <= pwdata[7:0];
		end
	end

	// ==================================================
	// Hop decision
	assign dwell_done = dwell_r >= 16'(DWELL_CYC);
	assign nxt_i = nxt_idx(idx_r);
	assign first_i = nxt_idx(6'(size_r - 7'h01));

	always_comb begin
		stay_ev = (ctrl_r[chc_pkg::B_RSSI] && dwell_done
				&& rssi_now > signal_level_threshold)
			|| (ctrl_r[chc_pkg::B_PKT] && ctrl_r[chc_pkg::B_SYNC] && sync_found);
		hop_ev = (ctrl_r[chc_pkg::B_RSSI] && dwell_done
				&& rssi_now <= signal_level_threshold)
			|| (ctrl_r[chc_pkg::B_PKT] && ctrl_r[chc_pkg::B_PRE] && preamble_timeout)
			|| (ctrl_r[chc_pkg::B_PKT] && ctrl_r[chc_pkg::B_SYNC] && sync_timeout);
		hop_go = 1'b0;
		tune_go = 1'b0;
		tune_ch = chan_r;
		if (cmd_wr && cmd_op != chc_pkg::OP_STOP) begin
			tune_go = 1'b1;
			tune_ch = cmd_ch;
		end else if (st_r == chc_pkg::ST_DWELL && hop_ev && !stay_ev) begin
			hop_go = 1'b1;
			tune_go = 1'b1;
			tune_ch = hop_tab[nxt_i];
		end
	end

	// ==================================================
	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= chc_pkg::ST_IDLE;
			chan_r <= chc_pkg::RST_CHAN;
			idx_r <= 6'h00;
			dwell_r <= 16'h0000;
		end else if (cmd_wr) begin
			dwell_r <= 16'h0000;
			if (cmd_op != chc_pkg::OP_STOP) begin
				chan_r <= cmd_ch;
			end
			case (cmd_op)
				chc_pkg::OP_STOP: st_r <= chc_pkg::ST_IDLE;
				chc_pkg::OP_RX: begin
					st_r <= ctrl_r[chc_pkg::B_HOP] ? chc_pkg::ST_DWELL : chc_pkg::ST_STAY;
					// Host starts on first valid entry
					idx_r <= first_i;
				end
				chc_pkg::OP_TX: st_r <= chc_pkg::ST_TX;
				default: st_r <= chc_pkg::ST_STAY;
			endcase
		end else begin
			case (st_r)
				chc_pkg::ST_DWELL: begin
					if (stay_ev) begin
						st_r <= chc_pkg::ST_STAY;
					end else if (hop_go) begin
						idx_r <= nxt_i;
						chan_r <= hop_tab[nxt_i];
						dwell_r <= 16'h0000;
					end else if (!dwell_done) begin
						dwell_r <= dwell_r + 16'h0001;
					end
				end
				chc_pkg::ST_TX: begin
					if (tx_done) begin
						st_r <= chc_pkg::ST_IDLE;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hop_pin <= 1'b0;
			wrap_pin <= 1'b0;
		end else if (hop_go) begin
			hop_pin <= ~hop_pin;
			if (nxt_i <= idx_r) begin
				wrap_pin <= ~wrap_pin;
			end
		end
	end

	// ==================================================
	// Synthesizer outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			synth_word <= 28'h0000000;
			synth_load <= 1'b0;
			oscillator_count_value <= 16'h0000;
			osc_count_ext <= 1'b0;
			out_div <= 5'h04;
		end else begin
			out_div <= chc_pkg::outdiv_of(band_r);
			synth_load <= tune_go;
			if (tune_go) begin
				synth_word <= synth_calc(tune_ch);
				osc_count_ext <= cmd_wr && cmd_op == chc_pkg::OP_HOP;
				if (cmd_wr && cmd_op == chc_pkg::OP_HOP) begin
					oscillator_count_value <= pwdata[chc_pkg::CMD_VCO_LSB +: 16];
				end
			end
		end
	end

	// ==================================================
	// Amplifier ramps
	// Ramp with transmit state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_ramp_on <= 1'b0;
		end else begin
			pa_ramp_on <= st_r == chc_pkg::ST_TX;
		end
	end

	chc_ramp i_chc_ramp (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (amplifier_mode_setting[chc_pkg::AMP_EXT_BIT]),
		.up      (pa_ramp_on),
		.tc      (ramp_time_code),
		.level_r (external_amp_ramp_out)
	);

	// ==================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_word;
		tune_go |=> synth_load && synth_word == synth_calc($past(tune_ch));
	endproperty
	a_word: assert property (p_word) else $error("synth word wrong");
	property p_div;
		$stable(band_r) |=> out_div == chc_pkg::outdiv_of($past(band_r));
	endproperty
	a_div: assert property (p_div) else $error("divider wrong");
	property p_reuse;
		cmd_wr && cmd_op == chc_pkg::OP_RX && !pwdata[chc_pkg::CMD_CHV]
			|=> $stable(chan_r);
	endproperty
	a_reuse: assert property (p_reuse) else $error("channel not reused");
	property p_skip;
		hop_go |=> hop_tab[idx_r] != chc_pkg::SKIP && chan_r == hop_tab[idx_r];
	endproperty
	a_skip: assert property (p_skip) else $error("skip entry used");
	property p_size;
		hop_go |=> {1'b0, idx_r} < size_r;
	endproperty
	a_size: assert property (p_size) else $error("index past size");
	property p_rssi;
		st_r == chc_pkg::ST_DWELL && !cmd_wr && ctrl_r[chc_pkg::B_RSSI] && dwell_done
			&& rssi_now > signal_level_threshold |=> st_r == chc_pkg::ST_STAY;
	endproperty
	a_rssi: assert property (p_rssi) else $error("no stay on rssi");
	property p_raw;
		st_r == chc_pkg::ST_DWELL && !ctrl_r[chc_pkg::B_PKT] && !dwell_done
			&& !cmd_wr |=> st_r == chc_pkg::ST_DWELL && $stable(chan_r);
	endproperty
	a_raw: assert property (p_raw) else $error("timeout used without packets");
	property p_stay;
		st_r == chc_pkg::ST_STAY && !cmd_wr |=> st_r == chc_pkg::ST_STAY;
	endproperty
	a_stay: assert property (p_stay) else $error("left kept channel");
	property p_pin;
		hop_go |=> hop_pin != $past(hop_pin);
	endproperty
	a_pin: assert property (p_pin) else $error("hop pin idle");
	property p_vco;
		cmd_wr && cmd_op == chc_pkg::OP_HOP |=> osc_count_ext
			&& oscillator_count_value == $past(pwdata[31:16]);
	endproperty
	a_vco: assert property (p_vco) else $error("host count not used");
	property p_pa;
		st_r == chc_pkg::ST_TX |=> pa_ramp_on;
	endproperty
	a_pa: assert property (p_pa) else $error("no ramp in transmit");
	property p_hopstart;
		cmd_wr && cmd_op == chc_pkg::OP_RX && ctrl_r[chc_pkg::B_HOP]
			|=> st_r == chc_pkg::ST_DWELL;
	endproperty
	a_hopstart: assert property (p_hopstart) else $error("hop not started");

	c_hop: cover property (hop_go);
	c_wrap: cover property (hop_go && nxt_i <= idx_r);
	c_stay: cover property (st_r == chc_pkg::ST_DWELL ##1 st_r == chc_pkg::ST_STAY);
	c_tx: cover property (pa_ramp_on ##1 !pa_ramp_on);
endmodule : chc_top
`default_nettype wire

// ==== chc_host.sv ====
// Host model: APB master that configures the channel hop block
`timescale 1ns/10ps
`default_nettype none
module chc_host (
	input  wire logic        pclk,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// ==================================================
	// Bus cycle
	// Waits as long as the slave needs; only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : chc_host
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench for the channel hop control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  rssi_now = 8'h10;
	logic        preamble_timeout = 1'b0;
	logic        sync_timeout = 1'b0;
	logic        tx_done = 1'b0;
	logic        sync_found = 1'b0;
	logic [27:0] synth_word;
	logic [4:0]  out_div;
	logic [15:0] osc;
	logic [7:0]  ext;
	logic        synth_load, osc_ext, hop_pin, wrap_pin, pa_on, e, h;
	int          mismatches = 0;
	int          checks = 0;
	localparam logic [27:0] INTE = 28'h3C;
	localparam logic [27:0] FRAC = 28'h0C0000;
	localparam logic [27:0] STEP = 28'h1234;
	always #2 pclk = ~pclk;
	chc_top #(.DWELL_CYC(4)) i_chc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rssi_now(rssi_now),
		.preamble_timeout(preamble_timeout), .sync_timeout(sync_timeout),
		.sync_found(sync_found), .tx_done(tx_done), .synth_word(synth_word),
		.out_div(out_div),
		.synth_load(synth_load), .oscillator_count_value(osc), .osc_count_ext(osc_ext),
		.hop_pin(hop_pin), .wrap_pin(wrap_pin), .pa_ramp_on(pa_on),
		.external_amp_ramp_out(ext));
	chc_host i_chc_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// ==================================================
	// Helpers
	function automatic logic [27:0] wd(input logic [7:0] c);
		wd = (INTE << 19) + FRAC + {20'h0, c} * STEP;
	endfunction : wd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_chc_host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		i_chc_host.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd
	task automatic waitld(input logic [7:0] c);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (synth_load !== 1'b1 && n < 60);
		`CHK("synth_load", 1'b1, synth_load)
		`CHK("synth_word", wd(c), synth_word)
	endtask : waitld
	// ==================================================
	// Scenarios
	task automatic t_reset_band;
		logic [4:0] dv [5];
		dv = '{5'h18, 5'h0C, 5'h0A, 5'h08, 5'h04};
		`CHK("out_div rst", 5'h04, out_div)
		`CHK("ramp rst", 8'h00, ext)
		rd(chc_pkg::A_FRAC);
		`CHK("frac rst", 32'h00080000, q)
		rd(chc_pkg::A_SIZE);
		`CHK("size rst", 32'h00000040, q)
		rd(12'h030);
		`CHK("unmapped", 1'b1, e)
		for (int b = 0; b < 5; b++) begin
			wr(chc_pkg::A_BAND, b);
			repeat (2) @(posedge pclk);
			`CHK("out_div", dv[b], out_div)
		end
	endtask : t_reset_band
	task automatic t_channel;
		wr(chc_pkg::A_INTE, INTE);
		wr(chc_pkg::A_FRAC, FRAC);
		wr(chc_pkg::A_STEP, STEP);
		wr(chc_pkg::A_CMD, 32'h00000200);
		waitld(8'h00);
		wr(chc_pkg::A_CMD, 32'h0000030C);
		waitld(8'h0C);
		wr(chc_pkg::A_CMD, 32'h00000000);
		wr(chc_pkg::A_CMD, 32'h00000200);
		waitld(8'h0C);
		wr(chc_pkg::A_CMD, 32'h00000000);
	endtask : t_channel
	task automatic t_hop;
		wr(12'h104, 32'h07);
		wr(12'h108, 32'h09);
		wr(12'h10C, 32'h0B);
		wr(chc_pkg::A_SIZE, 32'h03);
		wr(chc_pkg::A_THR, 32'h80);
		wr(chc_pkg::A_CTRL, 32'h03);
		wr(chc_pkg::A_CMD, 32'h00000307);
		waitld(8'h07);
		h = hop_pin;
		waitld(8'h09);
		`CHK("hop_pin", ~h, hop_pin)
		h = wrap_pin;
		waitld(8'h07);
		`CHK("wrap_pin", ~h, wrap_pin)
		rssi_now <= 8'hC0;
		repeat (12) @(posedge pclk);
		h = hop_pin;
		rd(chc_pkg::A_STAT);
		`CHK("stay", 2'h2, q[1:0])
		repeat (20) @(posedge pclk);
		`CHK("stay pin", h, hop_pin)
		wr(chc_pkg::A_CMD, 32'h00000000);
	endtask : t_hop
	task automatic t_timeout(input logic [31:0] ctl);
		wr(chc_pkg::A_CTRL, ctl);
		wr(chc_pkg::A_CMD, 32'h00000307);
		waitld(8'h07);
		h = hop_pin;
		preamble_timeout <= 1'b1;
		@(posedge pclk);
		preamble_timeout <= 1'b0;
		if (ctl[chc_pkg::B_PKT]) begin
			waitld(8'h09);
			sync_timeout <= 1'b1;
			@(posedge pclk);
			sync_timeout <= 1'b0;
			waitld(8'h07);
			sync_found <= 1'b1;
			@(posedge pclk);
			sync_found <= 1'b0;
			rd(chc_pkg::A_STAT);
			`CHK("sync stay", 2'h2, q[1:0])
		end else begin
			repeat (10) @(posedge pclk);
			`CHK("no hop", h, hop_pin)
		end
		wr(chc_pkg::A_CMD, 32'h00000000);
	endtask : t_timeout
	task automatic t_manual;
		wr(chc_pkg::A_CMD, 32'hABCD0702);
		waitld(8'h02);
		`CHK("osc ext", 1'b1, osc_ext)
		`CHK("osc val", 16'hABCD, osc)
		wr(chc_pkg::A_CMD, 32'h00000000);
	endtask : t_manual
	task automatic t_tx(input logic [3:0] tc);
		wr(chc_pkg::A_RAMP, tc);
		wr(chc_pkg::A_CMD, 32'h00000505);
		waitld(8'h05);
		`CHK("osc ext tx", 1'b0, osc_ext)
		@(posedge pclk);
		`CHK("pa on", 1'b1, pa_on)
		repeat (300) @(posedge pclk);
		// Slow code still climbing, fast code at top
		`CHK("ramp up", tc == 4'h0, ext === 8'hFF)
		tx_done <= 1'b1;
		@(posedge pclk);
		tx_done <= 1'b0;
		repeat (6000) @(posedge pclk);
		`CHK("pa off", 1'b0, pa_on)
		`CHK("ramp down", 8'h00, ext)
	endtask : t_tx
	// ==================================================
	// Sequence
	task automatic wrap_up;
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_band();
		t_channel();
		t_hop();
		t_timeout(32'h1D);
		t_timeout(32'h05);
		t_manual();
		wr(chc_pkg::A_AMP, 32'h80);
		t_tx(4'h0);
		t_tx(4'hF);
		wr(chc_pkg::A_AMP, 32'h00);
		wr(chc_pkg::A_CMD, 32'h00000505);
		repeat (300) @(posedge pclk);
		`CHK("ramp off", 8'h00, ext)
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		wrap_up();
	end
endmodule : tb
`undef CHK
`default_nettype wire
